// [design/pts_timer.v]
// period timer with prescaler, postscaler and apb register slave
//
// The APB register port is this design's own decision.
`include "pts_defines.vh"
module pts_timer (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    output wire irq
);
    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    reg [7:0] ctrl_q;
    reg [7:0] count_q;
    reg [7:0] period_q;
    reg [7:0] flags_q;
    reg [7:0] enables_q;
    reg [6:0] intctl_hi_q;
    reg intctl_b0_q;
    reg b0_init_q;
    wire tick;
    wire match;
    wire event_pulse;
    wire [7:0] intctl;
    wire wr_en;
    wire rd_en;
    wire [7:0] idx;
    wire mapped;
    wire lane0;

    // true when the address is the aligned word of the wanted register index
    function is_idx;
        input [31:0] addr;
        input [7:0] want;
        begin
            is_idx = (addr[31:10] == 22'h0) && (addr[9:2] == want) && (addr[1:0] == 2'h0);
        end
    endfunction

    // -----------------------------------------------------------------
    // apb decode
    // -----------------------------------------------------------------
    // zero-wait slave: every access completes in its first access cycle
    assign pready = 1'b1;
    assign idx = paddr[9:2];
    assign mapped = is_idx(paddr, `PTS_IDX_INTCTL) || is_idx(paddr, `PTS_IDX_FLAGS) ||
                    is_idx(paddr, `PTS_IDX_COUNT) || is_idx(paddr, `PTS_IDX_CTRL) ||
                    is_idx(paddr, `PTS_IDX_ENABLES) || is_idx(paddr, `PTS_IDX_PERIOD);
    assign pslverr = psel && penable && !mapped;
    assign wr_en = psel && penable && pwrite && mapped;
    assign rd_en = psel && penable && !pwrite && mapped;
    assign lane0 = pstrb[0];
    assign intctl = {intctl_hi_q, intctl_b0_q};

    // -----------------------------------------------------------------
    // scalers
    // -----------------------------------------------------------------
    pts_prescaler u_pre (
        .pclk(pclk),
        .presetn(presetn),
        .run(ctrl_q[`PTS_CTRL_RUN]),
        .sel(ctrl_q[`PTS_CTRL_PRE_HI:`PTS_CTRL_PRE_LO]),
        .tick(tick)
    );

    // match fires on the increment that wraps the count
    assign match = tick && (count_q == period_q); // see [RULE10]

    pts_postscaler u_post (
        .pclk(pclk),
        .presetn(presetn),
        .match(match),
        .sel(ctrl_q[`PTS_CTRL_POST_HI:`PTS_CTRL_POST_LO]),
        .event_pulse(event_pulse)
    );

    // -----------------------------------------------------------------
    // control and period registers
    // -----------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= `PTS_RST_CTRL; // see [RULE4]
            period_q <= `PTS_RST_PERIOD; // see [RULE6]
            enables_q <= `PTS_RST_ENABLES; // see [RULE8]
            intctl_hi_q <= `PTS_RST_INTCTL; // see [RULE9]
        end
        else if (wr_en && lane0)
        begin
            if (is_idx(paddr, `PTS_IDX_CTRL))
                ctrl_q <= pwdata[7:0] & `PTS_CTRL_MASK; // see [RULE4]
            else if (is_idx(paddr, `PTS_IDX_PERIOD))
                period_q <= pwdata[7:0];
            else if (is_idx(paddr, `PTS_IDX_ENABLES))
                enables_q <= pwdata[7:0] & `PTS_ENABLES_MASK;
            else if (is_idx(paddr, `PTS_IDX_INTCTL))
                intctl_hi_q <= pwdata[7:1];
        end
    end

    // bit 0 is not reset; it is loaded at the first clock after release
    // so it holds a defined value without taking a port under reset
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            b0_init_q <= 1'b0;
        else
            b0_init_q <= 1'b1;
    end

    always @(posedge pclk)
    begin
        if (!b0_init_q)
            intctl_b0_q <= 1'b0; // see [RULE9]
        else if (wr_en && lane0 && is_idx(paddr, `PTS_IDX_INTCTL))
            intctl_b0_q <= pwdata[0];
    end

    // -----------------------------------------------------------------
    // counter
    // -----------------------------------------------------------------
    // a bus write wins over the increment in the same cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_q <= `PTS_RST_COUNT; // see [RULE5]
        else if (wr_en && lane0 && is_idx(paddr, `PTS_IDX_COUNT))
            count_q <= pwdata[7:0];
        else if (match)
            count_q <= 8'h00; // see [RULE10]
        else if (tick)
            count_q <= count_q + 8'h01; // see [RULE2]
    end

    // -----------------------------------------------------------------
    // flags
    // -----------------------------------------------------------------
    // write one to clear; a simultaneous event keeps its flag set
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_q <= `PTS_RST_FLAGS; // see [RULE7]
        else
        begin
            if (wr_en && lane0 && is_idx(paddr, `PTS_IDX_FLAGS))
                flags_q <= flags_q & ~(pwdata[7:0] & `PTS_FLAGS_MASK);
            if (event_pulse)
                flags_q[`PTS_EVT_BIT] <= 1'b1; // see [RULE11]
        end
    end

    // all three enables must be set for a request
    assign irq = flags_q[`PTS_EVT_BIT] && enables_q[`PTS_EVT_BIT] &&
                 intctl_hi_q[`PTS_PERIPHERAL_IRQ_ENABLE_BIT - 1] && intctl_hi_q[`PTS_GIE_BIT - 1]; // see [RULE11]

    // -----------------------------------------------------------------
    // read data
    // -----------------------------------------------------------------
    // registered read data, loaded in the setup cycle; unmapped reads zero
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            if (is_idx(paddr, `PTS_IDX_CTRL))
                prdata <= {24'h0, ctrl_q & `PTS_CTRL_MASK}; // see [RULE4]
            else if (is_idx(paddr, `PTS_IDX_COUNT))
                prdata <= {24'h0, count_q};
            else if (is_idx(paddr, `PTS_IDX_PERIOD))
                prdata <= {24'h0, period_q};
            else if (is_idx(paddr, `PTS_IDX_FLAGS))
                prdata <= {24'h0, flags_q & `PTS_FLAGS_MASK}; // see [RULE7]
            else if (is_idx(paddr, `PTS_IDX_ENABLES))
                prdata <= {24'h0, enables_q};
            else if (is_idx(paddr, `PTS_IDX_INTCTL))
                prdata <= {24'h0, intctl};
            else
                prdata <= 32'h0000_0000;
        end
    end

    // keep decode terms referenced for readers of the bus
    wire unused_ok;
    assign unused_ok = rd_en | (idx == 8'h00);
endmodule

// [design/pts_defines.vh]
// constants for the period timer with scalers
//
// Contract
// [RULE1] postscale field bits 6:3, code plus one matches
// [RULE2] timer runs only while run bit set
// [RULE3] prescale 00 by 1, 01 by 4, 1x by 16
// [RULE4] control clears on reset, bit 7 reads zero
// [RULE5] count register resets to zero
// [RULE6] period register resets to all ones
// [RULE7] event flag bit 1, flag bit 3 reads zero
// [RULE8] event enable bit 1 at 8Ch, resets zero
// [RULE9] global enable bit 7, peripheral bit 6
// [RULE10] count to period, wrap, send match pulse
// [RULE11] flag on postscale match, gated interrupt request
`ifndef PTS_DEFINES_VH
`define PTS_DEFINES_VH
// -----------------------------------------------------------------
// register indices (byte address is four times the index)
// -----------------------------------------------------------------
`define PTS_IDX_INTCTL 8'h0B
`define PTS_IDX_FLAGS 8'h0C
`define PTS_IDX_COUNT 8'h11
`define PTS_IDX_CTRL 8'h12
`define PTS_IDX_ENABLES 8'h8C
`define PTS_IDX_PERIOD 8'h92
// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define PTS_CTRL_POST_HI 6
`define PTS_CTRL_POST_LO 3
`define PTS_CTRL_RUN 2
`define PTS_CTRL_PRE_HI 1
`define PTS_CTRL_PRE_LO 0
`define PTS_CTRL_MASK 8'h7F
`define PTS_FLAGS_MASK 8'hF7
`define PTS_ENABLES_MASK 8'hF7
`define PTS_EVT_BIT 1
`define PTS_GIE_BIT 7
`define PTS_PERIPHERAL_IRQ_ENABLE_BIT 6
// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define PTS_RST_CTRL 8'h00
`define PTS_RST_COUNT 8'h00
`define PTS_RST_PERIOD 8'hFF
`define PTS_RST_FLAGS 8'h00
`define PTS_RST_ENABLES 8'h00
`define PTS_RST_INTCTL 7'h00
// -----------------------------------------------------------------
// prescale dividers
// -----------------------------------------------------------------
`define PTS_PRE_DIV4 4'h3
`define PTS_PRE_DIV16 4'hF
`endif

// [design/pts_prescaler.v]
// clock prescaler producing a one-cycle tick enable
`include "pts_defines.vh"
module pts_prescaler (
    input wire pclk,
    input wire presetn,
    input wire run,
    input wire [1:0] sel,
    output wire tick
);
    reg [3:0] cnt_q;
    wire [3:0] limit;

    // 00 passes every clock, 01 every fourth, 1x every sixteenth
    assign limit = sel[1] ? `PTS_PRE_DIV16 : (sel[0] ? `PTS_PRE_DIV4 : 4'h0); // see [RULE3]
    assign tick = run && (cnt_q >= limit); // see [RULE2]

    // divider holds while stopped so a restart resumes the phase
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 4'h0;
        else if (run)
        begin
            if (cnt_q >= limit)
                cnt_q <= 4'h0;
            else
                cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

// [design/pts_postscaler.v]
// output postscaler: one event per selected number of matches
`include "pts_defines.vh"
module pts_postscaler (
    input wire pclk,
    input wire presetn,
    input wire match,
    input wire [3:0] sel,
    output wire event_pulse
);
    reg [3:0] cnt_q;

    // code n gives ratio n+1; comparing with >= tolerates a lowered code
    assign event_pulse = match && (cnt_q >= sel); // see [RULE1]

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 4'h0;
        else if (match)
        begin
            if (cnt_q >= sel)
                cnt_q <= 4'h0;
            else
                cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

// [verification/pts_timer_properties.sv]
// port-level assertions for the period timer
module pts_timer_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic irq
);
    logic acc;
    logic mapped;
    logic [2:0] gate_q;
    // ----
    // shadow of the three interrupt gates, from bus writes
    // ----
    assign acc = psel && penable;
    assign mapped = paddr inside {32'h2C, 32'h30, 32'h44, 32'h48, 32'h230, 32'h248};
    // the shadow lets irq be judged without seeing inside the block
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gate_q <= 3'h0;
        else if (acc && pwrite && pstrb[0] && paddr == 32'h2C)
            gate_q[2:1] <= pwdata[7:6];
        else if (acc && pwrite && pstrb[0] && paddr == 32'h230)
            gate_q[0] <= pwdata[1];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_unmapped_err: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access refused");
    chk_ctrl_top_bit: assert property (acc && !pwrite && paddr == 32'h48 |-> !prdata[7])
        else $error("control bit 7 read as one");
    chk_flag_bit_three: assert property (acc && !pwrite && paddr == 32'h30 |-> !prdata[3])
        else $error("flag bit 3 read as one");
    chk_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_irq_gated: assert property (irq |-> gate_q == 3'h7)
        else $error("irq with a gate closed");
    chk_gie_off: assert property (acc && pwrite && pstrb[0] && paddr == 32'h2C && !pwdata[7] |=> !irq)
        else $error("irq after global gate cleared");
endmodule
bind pts_timer pts_timer_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready, .pslverr, .prdata, .irq);

// [verification/pts_timer_tb_top.sv]
// self-checking bench for the period timer
`include "pts_defines.vh"
module pts_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic [31:0] rd;
    logic err;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    int t0;
    int c1;
    pts_timer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
        .pslverr, .prdata, .irq);
    always #4 pclk = ~pclk;
    // cycle stamp for intervals; a hang ends the run as a mismatch
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s exp %h got %h", what, exp, got);
        end
    endtask
    // ----
    // apb transfers: held until pready is seen at an edge
    // ----
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {22'h0, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask
    task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        cmp(what, {24'h0, exp}, rd);
    endtask
    task automatic wait_irq();
        @(posedge pclk);
        while (irq !== 1'b1)
            @(posedge pclk);
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
    endtask
    task automatic reset_vals();
        rchk("ctrl", `PTS_IDX_CTRL, 8'h00);
        rchk("count", `PTS_IDX_COUNT, 8'h00);
        rchk("period", `PTS_IDX_PERIOD, 8'hFF);
        rchk("flags", `PTS_IDX_FLAGS, 8'h00);
        rchk("enables", `PTS_IDX_ENABLES, 8'h00);
        rchk("intctl", `PTS_IDX_INTCTL, 8'h00);
    endtask
    // ----
    // main sequence
    // ----
    initial
    begin
        do_reset();
        reset_vals();
        wr(`PTS_IDX_CTRL, 8'hFB);
        rchk("ctrl", `PTS_IDX_CTRL, 8'h7B);
        wr(`PTS_IDX_COUNT, 8'h05);
        repeat (20) @(posedge pclk);
        rchk("count", `PTS_IDX_COUNT, 8'h05);
        xfer(1'b0, 8'h10, 8'h00);
        cmp("slverr", 32'h1, {31'h0, err});
        // division judged from count growth between two stamped reads
        for (int k = 0; k < 4; k++)
        begin
            wr(`PTS_IDX_CTRL, 8'h04 | 8'(k));
            wr(`PTS_IDX_COUNT, 8'h00);
            xfer(1'b0, `PTS_IDX_COUNT, 8'h00);
            t0 = cyc;
            c1 = rd;
            repeat (64) @(posedge pclk);
            xfer(1'b0, `PTS_IDX_COUNT, 8'h00);
            c1 = int'(rd) - c1 - (cyc - t0) / (k == 0 ? 1 : k == 1 ? 4 : 16);
            cmp("prescale", 32'h1, {31'h0, c1 >= -1 && c1 <= 1});
        end
        wr(`PTS_IDX_PERIOD, 8'h0F);
        wr(`PTS_IDX_INTCTL, 8'hC0);
        wr(`PTS_IDX_ENABLES, 8'h02);
        rchk("intctl", `PTS_IDX_INTCTL, 8'hC0);
        // first event may be partial, so the second interval is timed;
        // a flag left from the previous code is cleared first
        for (int p = 0; p < 16; p += (p == 1) ? 14 : 1)
        begin
            wr(`PTS_IDX_CTRL, {1'b0, 4'(p), 3'b100});
            wr(`PTS_IDX_FLAGS, 8'h02);
            wait_irq();
            t0 = cyc;
            wr(`PTS_IDX_FLAGS, 8'h02);
            wait_irq();
            cmp("event gap", 32'(16 * (p + 1)), 32'(cyc - t0));
        end
        wr(`PTS_IDX_CTRL, 8'h00);
        rchk("flags", `PTS_IDX_FLAGS, 8'h02);
        wr(`PTS_IDX_INTCTL, 8'h40);
        @(posedge pclk);
        cmp("irq", 32'h0, {31'h0, irq});
        wr(`PTS_IDX_INTCTL, 8'hC0);
        @(posedge pclk);
        cmp("irq", 32'h1, {31'h0, irq});
        wr(`PTS_IDX_ENABLES, 8'h00);
        @(posedge pclk);
        cmp("irq", 32'h0, {31'h0, irq});
        wr(`PTS_IDX_FLAGS, 8'h02);
        rchk("flags", `PTS_IDX_FLAGS, 8'h00);
        wr(`PTS_IDX_CTRL, 8'h7F);
        do_reset();
        reset_vals();
        end_sim();
    end
endmodule
